// ### psi_sample_if.sv
/*
  Sampling front of a 10-bit two-step converter: sample clock pin
  synchroniser, input hold, minimum rate watch, falling edge output
  latch with output valid delay.
  Assumes sample_clk_i and analog_i come from pins outside clk_i.
*/
`timescale 1ns/1ps
// Function
// - Each sample clock rising edge holds the input and starts a conversion.
// - Samples taken below the minimum rate are marked not valid.
// - Output word updates on the falling edge, after the output valid delay.
// - Results appear two and a half sample clocks after their rising edge.
// - Coarse and fine results of one sample are aligned into one word.
// - Coarse five bits on top, fine six bits give low five plus correction.
// - Coarse result selects exactly one of thirty-two ladder switches.
// - Out-of-range flag is high when input lies outside full scale.
module psi_sample_if
  import psi_pkg::*;
#(
  parameter int OUT_DLY = OUT_DLY_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    sample_clk_i,
  input  wire logic signed [AIN_W-1:0] analog_i,
  output logic [WORD_W-1:0]            sample_word_o,
  output logic                         out_of_range_o,
  output logic                         sample_valid_o,
  output logic                         word_strobe_o
);

  if (OUT_DLY < 1) begin : g_bad_dly
    $error("OUT_DLY must be at least one cycle");
  end

  psi_stage_if st ();

  psi_two_step u_two_step (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .st      (st.conv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first flop feeds only the second
  logic                    sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
  logic signed [AIN_W-1:0] ain_meta_reg,  ain_sync_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      ain_meta_reg  <= '0;
      ain_sync_reg  <= '0;
    end else begin
      sclk_meta_reg <= sample_clk_i;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      ain_meta_reg  <= analog_i;
      ain_sync_reg  <= ain_meta_reg;
    end
  end

  // Edge pulses of the synchronised sample clock
  logic rise_pulse;
  logic fall_pulse;
  assign rise_pulse = sclk_sync_reg & ~sclk_prev_reg;
  assign fall_pulse = ~sclk_sync_reg & sclk_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Input hold and rate watch
  logic              ain_over;
  logic [WORD_W-1:0] ain_code;
  logic [GAP_W-1:0]  gap_reg,       gap_next;
  logic [WORD_W-1:0] held_code_reg, held_code_next;
  logic              held_over_reg, held_over_next;
  logic              held_ok_reg,   held_ok_next;

  // Out of range inputs clip to the end codes, flag raised
  always_comb begin
    ain_over = (ain_sync_reg > AIN_POS_FS) || (ain_sync_reg < AIN_NEG_FS);
    if (ain_sync_reg > AIN_POS_FS) begin
      ain_code = WORD_MAX;
    end else if (ain_sync_reg < AIN_NEG_FS) begin
      ain_code = WORD_RST;
    end else begin
      ain_code = WORD_W'(ain_sync_reg + CODE_OFS);
    end
  end

  // A long gap since the last rising edge means the hold stage has drooped
  // into saturation, so that sample is marked unusable, not dropped
  always_comb begin
    gap_next       = (gap_reg == GAP_SAT) ? gap_reg : GAP_W'(gap_reg + 1'b1);
    held_code_next = held_code_reg;
    held_over_next = held_over_reg;
    held_ok_next   = held_ok_reg;
    if (rise_pulse) begin
      gap_next       = '0;
      held_code_next = ain_code;
      held_over_next = ain_over;
      // Gap reads one less than the edge-to-edge period here, so a
      // period of exactly the limit still counts as in rate
      held_ok_next   = (gap_reg < GAP_W'(MAX_PERIOD_CYC));
    end
  end

  // Hold registers; gap starts saturated so the first sample is not valid
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gap_reg       <= GAP_SAT;
      held_code_reg <= WORD_RST;
      held_over_reg <= 1'b0;
      held_ok_reg   <= 1'b0;
    end else begin
      gap_reg       <= gap_next;
      held_code_reg <= held_code_next;
      held_over_reg <= held_over_next;
      held_ok_reg   <= held_ok_next;
    end
  end

  // Each rising edge steps the pipeline, which yields the
  // two-cycle part of the latency
  assign st.advance   = rise_pulse;
  assign st.hold_code = held_code_reg;
  assign st.hold_over = held_over_reg;
  assign st.hold_ok   = held_ok_reg;

  ////////////////////////////////////////////////////////////////////////
  // Falling edge latch. The word is taken from the pipeline when the delay
  // expires; a rising edge inside the delay would overtake it, which only
  // happens above the rated sample rate.
  logic [OUT_DLY-1:0] dly_reg,   dly_next;
  logic [OUT_DLY:0]   dly_tap;
  logic               out_load;
  logic [WORD_W-1:0]  word_reg,  word_next;
  logic               over_reg,  over_next;
  logic               valid_reg, valid_next;
  logic               strobe_reg;

  always_comb begin
    dly_tap    = {dly_reg, fall_pulse};
    dly_next   = dly_tap[OUT_DLY-1:0];
    out_load   = dly_tap[OUT_DLY-1];  // Half cycle after step two
    word_next  = word_reg;
    over_next  = over_reg;
    valid_next = valid_reg;
    if (out_load) begin
      word_next  = st.word;
      over_next  = st.word_over;
      valid_next = st.word_ok;
    end
  end

  // Output word and flags hold between falling edges; the strobe is a one-cycle pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dly_reg    <= '0;
      word_reg   <= WORD_RST;
      over_reg   <= 1'b0;
      valid_reg  <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      dly_reg    <= dly_next;
      word_reg   <= word_next;
      over_reg   <= over_next;
      valid_reg  <= valid_next;
      strobe_reg <= out_load;
    end
  end

  assign sample_word_o  = word_reg;
  assign out_of_range_o = over_reg;
  assign sample_valid_o = valid_reg;
  assign word_strobe_o  = strobe_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks, with a shadow of the hold history for the latency check
  localparam int A_DLY = OUT_DLY;
  logic [WORD_W-1:0] a_ref1_reg, a_ref2_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      a_ref1_reg <= WORD_RST;
      a_ref2_reg <= WORD_RST;
    end else if (rise_pulse) begin
      a_ref1_reg <= held_code_reg;
      a_ref2_reg <= a_ref1_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_fall_seen;
    fall_pulse;
  endsequence

  sequence s_out_update;
    ##A_DLY word_strobe_o;
  endsequence

  a_hold_on_rise: assert property (
    rise_pulse |=> (held_code_reg == $past(ain_code)) && (gap_reg == '0))
    else $error("input not held on sample clock rising edge");

  a_rate_invalid: assert property (
    (rise_pulse && gap_reg >= GAP_W'(MAX_PERIOD_CYC)) |=> !held_ok_reg)
    else $error("sample after a long gap not marked invalid");

  a_out_on_fall: assert property (
    s_fall_seen |-> s_out_update)
    else $error("output not updated one valid delay after falling edge");

  a_strobe_cause: assert property (
    word_strobe_o |-> $past(fall_pulse, A_DLY))
    else $error("output updated without a falling edge");

  a_latency_word: assert property (
    word_strobe_o |-> (sample_word_o == a_ref2_reg))
    else $error("output word is not the sample held two rising edges earlier");

  a_range_flag: assert property (
    rise_pulse |=> (held_over_reg == (($past(ain_sync_reg) > AIN_POS_FS) ||
                                      ($past(ain_sync_reg) < AIN_NEG_FS))))
    else $error("out-of-range flag does not follow the input level");

endmodule : psi_sample_if

// ### psi_pkg.sv
/*
  Shared constants of the sampled two-step converter interface: word
  layout, ladder size, input range limits and the timing counts.
  Assumes a 200 MHz system clock that oversamples the sample clock pin.
*/
package psi_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Word layout
  localparam int WORD_W   = 10;   // Parallel result word
  localparam int COARSE_W = 5;    // Coarse flash stage
  localparam int FINE_W   = 6;    // Fine flash stage, incl. correction bit
  localparam int LADDER_N = 32;   // Residue ladder switches
  localparam int AIN_W    = 12;   // Signed input level, one count per code step

  localparam logic [WORD_W-1:0]       WORD_RST   = 10'h000;
  localparam logic [WORD_W-1:0]       WORD_MAX   = 10'h3FF;
  localparam logic signed [AIN_W-1:0] AIN_POS_FS = 12'sh1FF;  // +FS
  localparam logic signed [AIN_W-1:0] AIN_NEG_FS = 12'shE00;  // -FS
  localparam logic signed [AIN_W-1:0] CODE_OFS   = 12'sh200;  // Offset binary

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int MIN_RATE_MSPS  = 10;
  localparam int MAX_PERIOD_NS  = 1000 / MIN_RATE_MSPS;
  localparam int MAX_PERIOD_CYC = MAX_PERIOD_NS * CLK_MHZ / 1000;  // Rounded down
  localparam int GAP_W          = 6;
  localparam logic [GAP_W-1:0] GAP_SAT = GAP_W'(MAX_PERIOD_CYC + 1);

  localparam int OUTPUT_VALID_DELAY_NS = 10;
  localparam int OUT_DLY_RAW = (OUTPUT_VALID_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int OUT_DLY_CYC = (OUT_DLY_RAW < 1) ? 1 : OUT_DLY_RAW;

endpackage : psi_pkg

// ### psi_stage_if.sv
/*
  Carrier between the sampling front and the two-step pipeline.
  Assumes both ends share clk_i; advance is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface psi_stage_if
  import psi_pkg::*;
  ();
  logic              advance;    // One pulse per sample clock rising edge
  logic [WORD_W-1:0] hold_code;  // Held input, offset binary, saturated
  logic              hold_over;  // Held input was out of range
  logic              hold_ok;    // Held input taken at a legal rate
  logic [WORD_W-1:0] word;       // Aligned result word
  logic              word_over;
  logic              word_ok;

  modport ctrl (output advance, hold_code, hold_over, hold_ok,
                input  word, word_over, word_ok);
  modport conv (input  advance, hold_code, hold_over, hold_ok,
                output word, word_over, word_ok);
endinterface : psi_stage_if

// ### psi_two_step.sv
/*
  Two-step conversion pipeline: coarse flash with ladder switch select,
  then fine flash with correction bit and aligned word assembly.
  Assumes advance pulses once per sample clock rising edge.
*/
`timescale 1ns/1ps
module psi_two_step
  import psi_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  psi_stage_if.conv st
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [LADDER_N-1:0] ladder_sel(input logic [COARSE_W-1:0] c);
    ladder_sel = LADDER_N'(1) << c;
  endfunction : ladder_sel

  function automatic logic [WORD_W-1:0] ladder_tap(input logic [LADDER_N-1:0] s);
    ladder_tap = WORD_RST;
    for (int i = 0; i < LADDER_N; i++) begin
      if (s[i]) begin
        ladder_tap = WORD_W'(i << (WORD_W - COARSE_W));
      end
    end
  endfunction : ladder_tap

  logic [WORD_W-1:0]   s1_code_reg,   s1_code_next;
  logic [COARSE_W-1:0] s1_coarse_reg, s1_coarse_next;
  logic [LADDER_N-1:0] s1_sel_reg,    s1_sel_next;
  logic                s1_over_reg,   s1_over_next;
  logic                s1_ok_reg,     s1_ok_next;
  logic                s1_valid_reg,  s1_valid_next;
  logic [FINE_W-1:0]   fine_reg,      fine_next;
  logic [WORD_W-1:0]   word_reg,      word_next;
  logic                over_reg,      over_next;
  logic                ok_reg,        ok_next;
  logic [FINE_W-1:0]   fine_calc;
  logic [COARSE_W:0]   top_calc;

  ////////////////////////////////////////////////////////////////////////
  // Both stages step on the same advance, so stage two always takes the
  // sample that stage one held one sample clock earlier
  always_comb begin
    s1_code_next   = s1_code_reg;
    s1_coarse_next = s1_coarse_reg;
    s1_sel_next    = s1_sel_reg;
    s1_over_next   = s1_over_reg;
    s1_ok_next     = s1_ok_reg;
    s1_valid_next  = s1_valid_reg;
    fine_next      = fine_reg;
    word_next      = word_reg;
    over_next      = over_reg;
    ok_next        = ok_reg;
    // Fine residue against the selected ladder tap
    fine_calc = FINE_W'(s1_code_reg - ladder_tap(s1_sel_reg));
    // Correction bit lands on the coarse code
    top_calc  = {1'b0, s1_coarse_reg} + {{COARSE_W{1'b0}}, fine_calc[FINE_W-1]};
    if (st.advance) begin
      s1_code_next   = st.hold_code;
      s1_coarse_next = st.hold_code[WORD_W-1 -: COARSE_W];
      s1_sel_next    = ladder_sel(st.hold_code[WORD_W-1 -: COARSE_W]);
      s1_over_next   = st.hold_over;
      s1_ok_next     = st.hold_ok;
      s1_valid_next  = 1'b1;
      fine_next      = fine_calc;
      // Carry out of the top saturates rather than wrapping
      word_next      = top_calc[COARSE_W] ? WORD_MAX
                       : {top_calc[COARSE_W-1:0], fine_calc[FINE_W-2:0]};
      over_next      = s1_over_reg;  // Flag stays paired with its word
      ok_next        = s1_ok_reg & s1_valid_reg;
    end
  end

  // Stage registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_code_reg   <= WORD_RST;
      s1_coarse_reg <= '0;
      s1_sel_reg    <= LADDER_N'(1);
      s1_over_reg   <= 1'b0;
      s1_ok_reg     <= 1'b0;
      s1_valid_reg  <= 1'b0;
      fine_reg      <= '0;
      word_reg      <= WORD_RST;
      over_reg      <= 1'b0;
      ok_reg        <= 1'b0;
    end else begin
      s1_code_reg   <= s1_code_next;
      s1_coarse_reg <= s1_coarse_next;
      s1_sel_reg    <= s1_sel_next;
      s1_over_reg   <= s1_over_next;
      s1_ok_reg     <= s1_ok_next;
      s1_valid_reg  <= s1_valid_next;
      fine_reg      <= fine_next;
      word_reg      <= word_next;
      over_reg      <= over_next;
      ok_reg        <= ok_next;
    end
  end

  assign st.word      = word_reg;
  assign st.word_over = over_reg;
  assign st.word_ok   = ok_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_ladder_one_hot: assert property (
    s1_valid_reg |-> ($onehot(s1_sel_reg) && s1_sel_reg[s1_coarse_reg]))
    else $error("ladder select is not one-hot on the coarse code");

  a_word_aligned: assert property (
    (st.advance && s1_valid_reg) |=> (word_reg == $past(s1_code_reg)))
    else $error("result word does not match the sample it belongs to");

  a_fine_combine: assert property (
    (st.advance && s1_valid_reg) |=>
      (word_reg[FINE_W-2:0] == fine_reg[FINE_W-2:0]) && !fine_reg[FINE_W-1] &&
      (word_reg[WORD_W-1 -: COARSE_W] == $past(s1_coarse_reg)))
    else $error("fine bits or correction bit wrong in result word");

endmodule : psi_two_step

// ### psi_capture_model.sv
/*
  Capture side model: makes the sample clock from the system clock and
  registers the result word with its flags on the update strobe.
  Assumes the bench sets the half period and the run request.
*/
`timescale 1ns/1ps
module psi_capture_model
  import psi_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              run_i,
  input  wire logic [4:0]        half_i,
  input  wire logic              strobe_i,
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic              over_i,
  input  wire logic              valid_i,
  output logic                   sample_clk_o,
  output logic [WORD_W-1:0]      cap_word_o,
  output logic                   cap_over_o,
  output logic                   cap_valid_o
);
  logic [4:0] cnt;

  // Equal high and low phases; a stop request finishes the high phase first
  initial begin
    sample_clk_o = 1'b0;
    cnt          = 5'd1;
  end
  always @(negedge clk_i) begin
    if (!run_i && !sample_clk_o) begin
      cnt <= 5'd1;
    end else if (cnt >= half_i) begin
      sample_clk_o <= ~sample_clk_o;
      cnt          <= 5'd1;
    end else begin
      cnt <= cnt + 5'd1;
    end
  end

  // Word and flags taken together on one edge, so they never mix samples
  always @(posedge clk_i) begin
    if (strobe_i) begin
      cap_word_o  <= word_i;
      cap_over_o  <= over_i;
      cap_valid_o <= valid_i;
    end
  end
endmodule : psi_capture_model

// ### test_pipelined_adc_sample_interface.sv
/*
  Self-checking bench of the sampling front: random levels and rates,
  a clock gap and a second reset, scored against a per-sample history.
  Assumes psi_pkg and the capture model are compiled first.
*/
`timescale 1ns/1ps
module test_pipelined_adc_sample_interface;
  import psi_pkg::*;
  localparam int DLY = 2;
  typedef struct {logic [WORD_W-1:0] word; logic over; logic valid;} psi_tb_exp_t;

  logic                    clk_i, reset_i, run, sclk;
  logic [4:0]              half;
  logic signed [AIN_W-1:0] analog_i;
  logic [WORD_W-1:0]       sample_word_o, cap_word;
  logic                    out_of_range_o, sample_valid_o, word_strobe_o;
  logic                    cap_over, cap_valid, prev, cap_chk;
  int                      errors, n_compared, seed, cyc, since, nrise;
  int                      qi[$], qt[$];
  psi_tb_exp_t             hist[int], ce;
  logic signed [AIN_W-1:0] corner[8] = '{-2048, -513, -512, -1, 0, 511, 512, 2047};

  psi_sample_if #(.OUT_DLY(DLY)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .sample_clk_i(sclk), .analog_i(analog_i),
    .sample_word_o(sample_word_o), .out_of_range_o(out_of_range_o),
    .sample_valid_o(sample_valid_o), .word_strobe_o(word_strobe_o));
  psi_capture_model cap (
    .clk_i(clk_i), .run_i(run), .half_i(half), .strobe_i(word_strobe_o),
    .word_i(sample_word_o), .over_i(out_of_range_o), .valid_i(sample_valid_o),
    .sample_clk_o(sclk), .cap_word_o(cap_word), .cap_over_o(cap_over),
    .cap_valid_o(cap_valid));

  ////////////////////////////////////////////////////////////////////////
  // Expected word: offset binary, clipped at both ends of the range
  function automatic psi_tb_exp_t expect_of(logic signed [AIN_W-1:0] x, int period);
    psi_tb_exp_t r;
    r.over  = (x > AIN_POS_FS) || (x < AIN_NEG_FS);
    r.word  = (x > AIN_POS_FS) ? WORD_MAX : (x < AIN_NEG_FS) ? WORD_RST : WORD_W'(x + CODE_OFS);
    r.valid = period <= MAX_PERIOD_CYC;
    return r;
  endfunction : expect_of

  task automatic fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) fail($sformatf("%s is %b, expected %b", what, got, exp));
  endtask : cmp_bit

  task automatic cmp_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) fail($sformatf("update %0d cycles after fall", got));
  endtask : cmp_range

  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Waits out one whole high phase; a stuck clock is a mismatch
  task automatic next_sample;
    int k;
    k = 0;
    while (sclk !== 1'b1 && k < 64) begin @(negedge clk_i); k++; end
    while (sclk !== 1'b0 && k < 64) begin @(negedge clk_i); k++; end
    if (k >= 64) fail("sample clock stuck");
  endtask : next_sample

  task automatic run_samples(input int n, input logic rnd_rate);
    for (int i = 0; i < n; i++) begin
      next_sample();
      analog_i = (i < 8) ? corner[i] : AIN_W'($random(seed) % 1100);
      if (rnd_rate) half = 5'(3 + ($unsigned($random(seed)) % 9));
    end
  endtask : run_samples

  task automatic check_reset_values;
    cmp_word(sample_word_o, WORD_RST);
    cmp_bit(out_of_range_o, 1'b0, "flag after reset");
    cmp_bit(sample_valid_o, 1'b0, "valid after reset");
    cmp_bit(word_strobe_o, 1'b0, "strobe after reset");
  endtask : check_reset_values

  ////////////////////////////////////////////////////////////////////////
  // Clock; the watchdog allows several times the longest expected run
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    errors++;
    wrap_up();
  end

  // Rise and fall monitor; the gap count starts saturated after reset
  always @(posedge clk_i) begin
    cyc++;
    if (reset_i) begin
      since = 1000;
      nrise = 0;
      prev  = 1'b0;
      qi.delete();
      qt.delete();
      hist.delete();
    end else begin
      since++;
      if (sclk && !prev) begin
        hist[nrise] = expect_of(analog_i, since);
        nrise++;
        since = 0;
      end
      if (!sclk && prev) begin
        qi.push_back(nrise - 3); // Early falls carry pipeline fill
        qt.push_back(cyc);
      end
      prev = sclk;
    end
  end

  // Every strobe is timed; those past pipeline fill are scored against the sample taken at the third rise before its fall
  always @(negedge clk_i) begin
    int i, t;
    if (!reset_i) begin
      if (cap_chk) begin
        cmp_word(cap_word, ce.word);
        cmp_bit(cap_over, ce.over, "captured flag");
        cmp_bit(cap_valid, ce.valid, "captured valid");
        cap_chk = 1'b0;
      end
      if (word_strobe_o === 1'b1) begin
        if (qi.size() == 0) fail("strobe without a falling edge");
        else begin
          i = qi.pop_front();
          t = qt.pop_front();
          cmp_range(cyc - t, DLY + 1, DLY + 1);
          if (i >= 0) begin
            ce = hist[i];
            cmp_word(sample_word_o, ce.word);
            cmp_bit(out_of_range_o, ce.over, "range flag");
            cmp_bit(sample_valid_o, ce.valid, "valid flag");
            cap_chk = 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_i  = 1'b1;
    run      = 1'b0;
    half     = 5'd5;
    analog_i = '0;
    seed     = 56344;
    errors   = 0;
    n_compared = 0;
    cap_chk  = 1'b0;
    cyc      = 0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check_reset_values();
    reset_i = 1'b0;
    run     = 1'b1;
    // Steady rate first, then random rates up to just past the limit
    run_samples(40, 1'b0);
    run_samples(300, 1'b1);
    // Idle gap: the first sample after it is delivered as not valid
    run = 1'b0;
    repeat (40) @(negedge clk_i);
    run  = 1'b1;
    half = 5'd6;
    run_samples(12, 1'b0);
    // Second reset with the clock parked low
    run = 1'b0;
    repeat (30) @(negedge clk_i);
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check_reset_values();
    reset_i = 1'b0;
    run     = 1'b1;
    run_samples(30, 1'b1);
    run = 1'b0;
    repeat (40) @(negedge clk_i);
    cmp_bit(qi.size() == 0, 1'b1, "every fall answered");
    wrap_up();
  end
endmodule : test_pipelined_adc_sample_interface
